/* File: temp_input_filter_alarms.sv */
// One temperature input channel: offset, range, filter and alarms.
// Assumes sample_valid_in pulses once per sampling period from
// same-clock logic, spaced further apart than one filter pass.
// Wire-off detector levels arrive asynchronously from the front end.
`timescale 1ns/1ps
`include "temp_filter_regs.svh"

module temp_input_filter_alarms
   import temp_filter_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic sample_valid_in,
   input wire logic signed [`SAMPLE_W-1:0] sample_in,
   input wire chan_cfg_s cfg_in,
   input wire alarm_lim_s lim_in,
   input wire logic alarm_clear_in,
   input wire logic wire_off_in,
   input wire logic wire_a_only_in,
   output logic signed [`SAMPLE_W-1:0] data_out,
   output logic data_valid_out,
   output logic chan_over_limit_flag_out,
   output logic chan_under_limit_flag_out,
   output alarm_vec_t proc_alarm_out,
   output logic rate_alarm_out,
   output logic wire_fault_out,
   output logic busy_out
);

   // ----------------------------------------------------------------
   // Range limit decoding
   // ----------------------------------------------------------------
   function automatic logic signed [`SAMPLE_W-1:0] range_lo(
      input sensor_kind_e kind,
      input logic [1:0] range
   );
      logic signed [`SAMPLE_W-1:0] v;
      v = `OHM_LO_0;
      if (kind == KIND_MV) begin
         v = range[0] ? `MV_LO_1 : `MV_LO_0;
      end else begin
         unique case (range)
            2'h0: v = `OHM_LO_0;
            2'h1: v = `OHM_LO_1;
            2'h2: v = `OHM_LO_2;
            2'h3: v = `OHM_LO_3;
         endcase
      end
      return v;
   endfunction

   function automatic logic signed [`SAMPLE_W-1:0] range_hi(
      input sensor_kind_e kind,
      input logic [1:0] range
   );
      logic signed [`SAMPLE_W-1:0] v;
      v = `OHM_HI_0;
      if (kind == KIND_MV) begin
         v = range[0] ? `MV_HI_1 : `MV_HI_0;
      end else begin
         unique case (range)
            2'h0: v = `OHM_HI_0;
            2'h1: v = `OHM_HI_1;
            2'h2: v = `OHM_HI_2;
            2'h3: v = `OHM_HI_3;
         endcase
      end
      return v;
   endfunction

   // ----------------------------------------------------------------
   // Wire-off pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] wire_meta_r;
   logic [1:0] wire_sync_r;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wire_meta_r <= 2'b00;
         wire_sync_r <= 2'b00;
      end else if (ce_in) begin
         wire_meta_r <= {wire_a_only_in, wire_off_in};
         wire_sync_r <= wire_meta_r;
      end
   end

   // ----------------------------------------------------------------
   // Sample conditioning
   // ----------------------------------------------------------------
   chan_state_e state_r;
   logic signed [`SAMPLE_W-1:0] prev_x_r;
   logic have_prev_r;
   logic primed_r;
   logic take;
   logic signed [7:0] off_code;
   logic signed [`SAMPLE_W-1:0] offset;
   logic signed [`SAMPLE_W-1:0] x_corr;
   logic signed [`SAMPLE_W-1:0] x_sel;
   logic over_raw;
   logic under_raw;
   logic seed;
   logic signed [`SAMPLE_W:0] dx;
   logic [`SAMPLE_W:0] dx_mag;
   logic [`SAMPLE_W+`MS_W:0] rate_lhs;
   logic [`SAMPLE_W+`MS_W:0] rate_rhs;
   logic rate_hit;
   logic signed [`SAMPLE_W-1:0] filt_y;
   logic filt_done;

   assign take = (state_r == ST_IDLE) && sample_valid_in;

   always_comb begin
      // Out-of-range codes are clamped so a bad setting stays bounded
      off_code = cfg_in.offset_code;
      if (off_code > `OFFSET_MAX) begin
         off_code = `OFFSET_MAX;
      end else if (off_code < -`OFFSET_MAX) begin
         off_code = -`OFFSET_MAX;
      end
      offset = '0;
      if (cfg_in.kind == KIND_OHM && cfg_in.copper) begin
         offset = `SAMPLE_W'(off_code * `OFFSET_STEP);
      end
      x_corr = sample_in + offset;
      over_raw = x_corr > range_hi(cfg_in.kind, cfg_in.range);
      under_raw = x_corr < range_lo(cfg_in.kind, cfg_in.range);
      x_sel = x_corr;
      if (wire_sync_r[0]) begin
         if (cfg_in.kind == KIND_MV) begin
            x_sel = cfg_in.float_mode ? cfg_in.scale_hi
                                      : `INT_FULL_SCALE;
            over_raw = 1'b1;
            under_raw = 1'b0;
         end else if (wire_sync_r[1]) begin
            x_sel = cfg_in.scale_hi;
            over_raw = 1'b1;
            under_raw = 1'b0;
         end else begin
            x_sel = cfg_in.scale_lo;
            over_raw = 1'b0;
            under_raw = 1'b1;
         end
      end
      // Forced values go straight out rather than creeping through
      seed = !primed_r || !cfg_in.float_mode || wire_sync_r[0] ||
             (cfg_in.filter_time_constant == '0);
      // |dx| / dt > trig becomes |dx| * 1000 > trig * dt_ms
      dx = {x_corr[`SAMPLE_W-1], x_corr} -
           {prev_x_r[`SAMPLE_W-1], prev_x_r};
      dx_mag = dx[`SAMPLE_W] ? `SAMPLE_W'(-dx) : dx;
      rate_lhs = (`SAMPLE_W+`MS_W+1)'(dx_mag * `MS_PER_S);
      rate_rhs = '0;
      if (!cfg_in.rate_trig[`SAMPLE_W-1]) begin
         rate_rhs = (`SAMPLE_W+`MS_W+1)'(
            $unsigned(cfg_in.rate_trig) * cfg_in.rts_ms);
      end
      rate_hit = have_prev_r && (rate_lhs > rate_rhs);
   end

   lag_filter #(
      .FRAC(`FRAC_BITS)
   ) u_filter (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .start_in(take),
      .seed_in(seed),
      .x_in(x_sel),
      .dt_ms_in(cfg_in.rts_ms),
      .ta_ms_in(cfg_in.filter_time_constant),
      .y_out(filt_y),
      .done_out(filt_done)
   );

   // ----------------------------------------------------------------
   // Sequencing and per-sample flags
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_r <= ST_IDLE;
         prev_x_r <= '0;
         have_prev_r <= 1'b0;
         primed_r <= 1'b0;
         busy_out <= 1'b0;
      end else if (ce_in) begin
         unique case (state_r)
            ST_IDLE: begin
               if (take) begin
                  prev_x_r <= x_corr;
                  have_prev_r <= 1'b1;
                  primed_r <= 1'b1;
                  busy_out <= 1'b1;
                  state_r <= ST_BUSY;
               end
            end
            ST_BUSY: begin
               if (filt_done) begin
                  busy_out <= 1'b0;
                  state_r <= ST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         chan_over_limit_flag_out <= 1'b0;
         chan_under_limit_flag_out <= 1'b0;
         wire_fault_out <= 1'b0;
         rate_alarm_out <= 1'b0;
      end else if (ce_in && take) begin
         // Disabling alarms hides wire-off from the range flags too
         chan_over_limit_flag_out <= over_raw && !cfg_in.alarms_off;
         chan_under_limit_flag_out <= under_raw && !cfg_in.alarms_off;
         wire_fault_out <= wire_sync_r[0];
         rate_alarm_out <= rate_hit && cfg_in.float_mode &&
                           !cfg_in.alarms_off;
      end
   end

   // ----------------------------------------------------------------
   // Output data
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         data_out <= '0;
         data_valid_out <= 1'b0;
      end else if (ce_in) begin
         data_valid_out <= filt_done;
         if (filt_done) begin
            data_out <= filt_y;
         end
      end
   end

   // ----------------------------------------------------------------
   // Process alarms with deadband and latching
   // ----------------------------------------------------------------
   logic signed [`SAMPLE_W-1:0] lim_arr [4];
   alarm_vec_t alarm_set;
   alarm_vec_t alarm_hold;
   alarm_vec_t alarm_nxt;

   assign lim_arr[0] = lim_in.ll;
   assign lim_arr[1] = lim_in.lo;
   assign lim_arr[2] = lim_in.hi;
   assign lim_arr[3] = lim_in.hh;

   generate
      for (genvar i = 0; i < 4; i++) begin : g_alarm
         if (i >= 2) begin : g_high
            assign alarm_set[i] = filt_y >= lim_arr[i];
            assign alarm_hold[i] =
               filt_y >= (lim_arr[i] - lim_in.deadband);
         end else begin : g_low
            assign alarm_set[i] = filt_y <= lim_arr[i];
            assign alarm_hold[i] =
               filt_y <= (lim_arr[i] + lim_in.deadband);
         end
      end
   endgenerate

   always_comb begin
      alarm_nxt = proc_alarm_out;
      if (filt_done) begin
         if (cfg_in.latch_en) begin
            alarm_nxt = proc_alarm_out;
         end else begin
            alarm_nxt = proc_alarm_out & alarm_hold;
         end
      end
      if (alarm_clear_in && cfg_in.latch_en) begin
         alarm_nxt = '0;
      end
      // A new crossing in the clear cycle still sets the bit
      if (filt_done) begin
         alarm_nxt = alarm_nxt | alarm_set;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         proc_alarm_out <= '0;
      end else if (ce_in) begin
         if (!cfg_in.float_mode || cfg_in.alarms_off) begin
            proc_alarm_out <= '0;
         end else begin
            proc_alarm_out <= alarm_nxt;
         end
      end
   end

endmodule

/* File: temp_filter_regs.svh */
// Constants for the temperature input conditioning block.
// Assumes samples in nano-ohms or nanovolts, signed, SAMPLE_W bits.
`ifndef TEMP_FILTER_REGS_SVH
`define TEMP_FILTER_REGS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define SAMPLE_W 48
`define MS_W 16
`define FRAC_BITS 16

// ----------------------------------------------------------------
// Resistance range limits, nano-ohms
// ----------------------------------------------------------------
`define OHM_LO_0 48'sh0000_3334_58ED
`define OHM_LO_1 48'sh0000_7735_9400
`define OHM_LO_2 48'sh0000_EE6B_2800
`define OHM_LO_3 48'sh0001_DCD6_5000
`define OHM_HI_0 48'sh0076_3EEF_2180
`define OHM_HI_1 48'sh00EC_AC3D_9980
`define OHM_HI_2 48'sh01D9_86BC_0500
`define OHM_HI_3 48'sh03B3_3F0F_5A00

// ----------------------------------------------------------------
// Millivolt range limits, nanovolts
// ----------------------------------------------------------------
`define MV_LO_0 48'shFFFF_FF0E_DCA2
`define MV_HI_0 48'sh0000_01DF_10A0
`define MV_LO_1 48'shFFFF_FF18_B3A8
`define MV_HI_1 48'sh0000_04B9_1F28

// ----------------------------------------------------------------
// Offsets, counts and time scaling
// ----------------------------------------------------------------
`define OFFSET_STEP 48'sh0000_0098_9680
`define OFFSET_MAX 8'sh63
`define INT_FULL_SCALE 48'sh0000_0000_7FFF
`define MS_PER_S 16'h03E8

`endif

/* File: temp_filter_pkg.sv */
// Types shared by the temperature conditioning block and its filter.
// Assumes temp_filter_regs.svh is on the include path.
`include "temp_filter_regs.svh"

package temp_filter_pkg;

   typedef enum logic {
      KIND_OHM = 1'b0,
      KIND_MV = 1'b1
   } sensor_kind_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_BUSY = 2'b10
   } chan_state_e;

   typedef enum logic [2:0] {
      F_IDLE = 3'b001,
      F_DIV = 3'b010,
      F_MUL = 3'b100
   } filt_state_e;

   typedef struct packed {
      logic float_mode;
      logic alarms_off;
      logic latch_en;
      logic copper;
      sensor_kind_e kind;
      logic [1:0] range;
      logic signed [7:0] offset_code;
      logic [`MS_W-1:0] filter_time_constant;
      logic [`MS_W-1:0] rts_ms;
      logic signed [`SAMPLE_W-1:0] rate_trig;
      logic signed [`SAMPLE_W-1:0] scale_hi;
      logic signed [`SAMPLE_W-1:0] scale_lo;
   } chan_cfg_s;

   typedef struct packed {
      logic signed [`SAMPLE_W-1:0] hh;
      logic signed [`SAMPLE_W-1:0] hi;
      logic signed [`SAMPLE_W-1:0] lo;
      logic signed [`SAMPLE_W-1:0] ll;
      logic signed [`SAMPLE_W-1:0] deadband;
   } alarm_lim_s;

   typedef logic [3:0] alarm_vec_t;

endpackage

/* File: lag_filter.sv */
// First-order lag filter with a sequential divider for its gain.
// Assumes start pulses only while idle; done pulses one cycle.
`timescale 1ns/1ps
`include "temp_filter_regs.svh"

module lag_filter
   import temp_filter_pkg::*;
#(
   parameter int FRAC = `FRAC_BITS
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic start_in,
   input wire logic seed_in,
   input wire logic signed [`SAMPLE_W-1:0] x_in,
   input wire logic [`MS_W-1:0] dt_ms_in,
   input wire logic [`MS_W-1:0] ta_ms_in,
   output logic signed [`SAMPLE_W-1:0] y_out,
   output logic done_out
);

   filt_state_e state_r;
   logic signed [`SAMPLE_W-1:0] x_r;
   logic [`MS_W+1:0] rem_r;
   logic [`MS_W:0] den_r;
   logic [FRAC:0] gain_r;
   logic [7:0] cnt_r;
   logic signed [`SAMPLE_W:0] diff;
   logic signed [`SAMPLE_W+FRAC+2:0] prod;
   logic signed [`SAMPLE_W+FRAC+2:0] step;

   // ----------------------------------------------------------------
   // Gain times difference
   // ----------------------------------------------------------------
   always_comb begin
      diff = {x_r[`SAMPLE_W-1], x_r} - {y_out[`SAMPLE_W-1], y_out};
      prod = (`SAMPLE_W+FRAC+3)'(diff * $signed({1'b0, gain_r}));
      step = prod >>> FRAC;
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_r <= F_IDLE;
         x_r <= '0;
         rem_r <= '0;
         den_r <= '0;
         gain_r <= '0;
         cnt_r <= '0;
         y_out <= '0;
         done_out <= 1'b0;
      end else if (ce_in) begin
         done_out <= 1'b0;
         unique case (state_r)
            F_IDLE: begin
               if (start_in && seed_in) begin
                  // Bypass also reloads state, so re-enabling starts clean
                  y_out <= x_in;
                  done_out <= 1'b1;
               end else if (start_in) begin
                  x_r <= x_in;
                  rem_r <= {2'b00, dt_ms_in};
                  den_r <= {1'b0, dt_ms_in} + {1'b0, ta_ms_in};
                  gain_r <= '0;
                  cnt_r <= 8'(FRAC);
                  state_r <= F_DIV;
               end
            end
            F_DIV: begin
               // Gain is dt / (dt + TA) in FRAC fractional bits
               if (rem_r >= {1'b0, den_r}) begin
                  rem_r <= (rem_r - {1'b0, den_r}) << 1;
                  gain_r <= {gain_r[FRAC-1:0], 1'b1};
               end else begin
                  rem_r <= rem_r << 1;
                  gain_r <= {gain_r[FRAC-1:0], 1'b0};
               end
               if (cnt_r == 8'h00) begin
                  state_r <= F_MUL;
               end else begin
                  cnt_r <= cnt_r - 8'h01;
               end
            end
            F_MUL: begin
               y_out <= y_out + step[`SAMPLE_W-1:0];
               done_out <= 1'b1;
               state_r <= F_IDLE;
            end
         endcase
      end
   end

endmodule

/* File: owner_ctrl_model.sv */
// Owner controller model: takes each result the channel hands over.
// Assumes it shares the channel clock and sees every data_valid pulse.
`timescale 1ns/1ps
`include "temp_filter_regs.svh"
module owner_ctrl_model
   import temp_filter_pkg::*;
(
   input wire logic clk_in,
   input wire logic data_valid_in,
   input wire logic signed [`SAMPLE_W-1:0] data_in,
   input wire logic [7:0] flags_in,
   output logic signed [`SAMPLE_W-1:0] got_data_out,
   output logic [7:0] got_flags_out,
   output int got_count_out = 0
);
   // Flags are read with the data so a wire fault is seen at once
   always_ff @(posedge clk_in) begin
      if (data_valid_in) begin
         got_data_out <= data_in;
         got_flags_out <= flags_in;
         got_count_out <= got_count_out + 1;
      end
   end
endmodule

/* File: temp_filter_checker.sv */
// Timing and flag relations of the conditioning channel.
// Assumes ce_in stays high while timing is judged.
`timescale 1ns/1ps
`include "temp_filter_regs.svh"
module temp_filter_checker
   import temp_filter_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic sample_valid_in,
   input wire logic signed [`SAMPLE_W-1:0] sample_in,
   input wire chan_cfg_s cfg_in,
   input wire alarm_lim_s lim_in,
   input wire logic alarm_clear_in,
   input wire logic wire_off_in,
   input wire logic wire_a_only_in,
   input wire logic signed [`SAMPLE_W-1:0] data_out,
   input wire logic data_valid_out,
   input wire logic chan_over_limit_flag_out,
   input wire logic chan_under_limit_flag_out,
   input wire alarm_vec_t proc_alarm_out,
   input wire logic rate_alarm_out,
   input wire logic wire_fault_out,
   input wire logic busy_out
);
   logic take;
   logic lat_ok;
   logic alm_on;
   assign take = ce_in && sample_valid_in && !busy_out;
   assign alm_on = cfg_in.float_mode && !cfg_in.alarms_off;
   assign lat_ok = alm_on && cfg_in.latch_en && !alarm_clear_in;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   valid_time_a: assert property (take |-> ##[2:20] data_valid_out)
      else $error("result late");
   bypass_time_a: assert property (
      take && !cfg_in.float_mode |-> ##2 data_valid_out)
      else $error("bypass result not two cycles");
   range_off_a: assert property (take && cfg_in.alarms_off |=>
      !chan_over_limit_flag_out && !chan_under_limit_flag_out)
      else $error("range flag with alarms off");
   flag_excl_a: assert property (
      !(chan_over_limit_flag_out && chan_under_limit_flag_out))
      else $error("over and under together");
   int_proc_a: assert property (
      !cfg_in.float_mode |=> proc_alarm_out == 4'h0)
      else $error("process alarm in integer mode");
   int_rate_a: assert property (
      take && !cfg_in.float_mode |=> !rate_alarm_out)
      else $error("rate alarm in integer mode");
   // Integer mode forces full scale, float mode the configured value
   wire_mv_a: assert property (data_valid_out && wire_fault_out &&
      cfg_in.kind == KIND_MV && !cfg_in.alarms_off |->
      chan_over_limit_flag_out && data_out == (cfg_in.float_mode ?
      cfg_in.scale_hi : `INT_FULL_SCALE))
      else $error("millivolt wire off value wrong");
   latch_hold_a: assert property (
      (lat_ok && !$past(alarm_clear_in)) ##1 lat_ok |->
      ($past(proc_alarm_out) & ~proc_alarm_out) == 4'h0)
      else $error("latched alarm dropped");
   high_high_a: assert property (
      data_valid_out && alm_on && data_out >= lim_in.hh |->
      proc_alarm_out[3])
      else $error("high high alarm missing");
   band_hold_a: assert property (data_valid_out && alm_on &&
      $past(proc_alarm_out[2]) && data_out >= lim_in.hi - lim_in.deadband
      |-> proc_alarm_out[2])
      else $error("high alarm left deadband early");
   band_clear_a: assert property (data_valid_out && alm_on &&
      !cfg_in.latch_en && data_out < lim_in.hi - lim_in.deadband |->
      !proc_alarm_out[2])
      else $error("high alarm not cleared");
endmodule

bind temp_input_filter_alarms temp_filter_checker u_chk (
   .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
   .sample_valid_in(sample_valid_in), .sample_in(sample_in),
   .cfg_in(cfg_in), .lim_in(lim_in), .alarm_clear_in(alarm_clear_in),
   .wire_off_in(wire_off_in), .wire_a_only_in(wire_a_only_in),
   .data_out(data_out), .data_valid_out(data_valid_out),
   .chan_over_limit_flag_out(chan_over_limit_flag_out),
   .chan_under_limit_flag_out(chan_under_limit_flag_out),
   .proc_alarm_out(proc_alarm_out), .rate_alarm_out(rate_alarm_out),
   .wire_fault_out(wire_fault_out), .busy_out(busy_out));

/* File: temp_input_filter_alarms_test.sv */
// Bench for one conditioning channel: corner and random samples.
// Assumes owner model and checker compiled first; ce_in held high except in the frozen-sample test.
`timescale 1ns/1ps
`include "temp_filter_regs.svh"
module temp_input_filter_alarms_test;
   import temp_filter_pkg::*;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic sample_valid = 1'b0;
   logic signed [`SAMPLE_W-1:0] sample = '0;
   chan_cfg_s cfg = '0;
   alarm_lim_s lim = '{48'sh190, 48'sh12C, -48'sh12C, -48'sh190, 48'sh32};
   logic clr = 1'b0;
   logic ce = 1'b1;
   int held;
   logic wire_off = 1'b0;
   logic wire_a = 1'b0;
   logic signed [`SAMPLE_W-1:0] data, got_data;
   logic dvalid, over, under, rate, fault, busy;
   alarm_vec_t alarm;
   logic [7:0] got_flags;
   int got_count, fail_count = 0, comparisons = 0, cycles = 0;
   longint y, prev;
   bit first = 1'b1;
   alarm_vec_t exp_alarm = '0;
   longint lo_tab[6] = '{`OHM_LO_0, `OHM_LO_1, `OHM_LO_2, `OHM_LO_3,
      `MV_LO_0, `MV_LO_1};
   longint hi_tab[6] = '{`OHM_HI_0, `OHM_HI_1, `OHM_HI_2, `OHM_HI_3,
      `MV_HI_0, `MV_HI_1};
   longint alarm_seq[12] = '{64'sh15E, 64'sh104, 64'shF0, 64'sh1C2,
      64'sh17C, 64'sh154, -64'sh15E, -64'sh104, -64'shF0, -64'sh1A4,
      -64'sh168, 64'sh0};
   longint rate_seq[5] = '{64'sh0, 64'shA, 64'sh15, 64'shA, 64'shA};

   temp_input_filter_alarms u_dut (
      .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce),
      .sample_valid_in(sample_valid), .sample_in(sample), .cfg_in(cfg),
      .lim_in(lim), .alarm_clear_in(clr), .wire_off_in(wire_off),
      .wire_a_only_in(wire_a), .data_out(data), .data_valid_out(dvalid),
      .chan_over_limit_flag_out(over), .chan_under_limit_flag_out(under),
      .proc_alarm_out(alarm), .rate_alarm_out(rate),
      .wire_fault_out(fault), .busy_out(busy));
   owner_ctrl_model u_owner (.clk_in(clk_in), .data_valid_in(dvalid),
      .data_in(data), .flags_in({fault, rate, alarm, over, under}),
      .got_data_out(got_data), .got_flags_out(got_flags),
      .got_count_out(got_count));

   initial begin
      forever #2 clk_in = ~clk_in;
   end

   task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic final_report();
      if (fail_count == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         final_report();
      end
   end

   task automatic do_reset();
      @(negedge clk_in);
      rst_in <= 1'b1;
      repeat (3) @(negedge clk_in);
      rst_in <= 1'b0;
      first = 1'b1;
      exp_alarm = '0;
   endtask

   // Expected result is worked out before the sample goes in
   task automatic send(longint s);
      longint x, e, g, d;
      int oc, c0, n, k;
      bit ov, un, rt;
      alarm_vec_t st, hd;
      oc = cfg.offset_code;
      oc = oc > 99 ? 99 : (oc < -99 ? -99 : oc);
      x = s;
      if (cfg.kind == KIND_OHM && cfg.copper)
         x = x + oc * `OFFSET_STEP;
      k = cfg.kind == KIND_MV ? 4 + cfg.range[0] : cfg.range;
      ov = x > hi_tab[k];
      un = x < lo_tab[k];
      g = (longint'(cfg.rts_ms) <<< 16) /
         (longint'(cfg.rts_ms) + longint'(cfg.filter_time_constant));
      if (wire_off) begin
         ov = cfg.kind == KIND_MV || wire_a;
         un = !ov;
         e = !ov ? cfg.scale_lo : ((cfg.kind == KIND_MV &&
            !cfg.float_mode) ? `INT_FULL_SCALE : cfg.scale_hi);
      end else if (first || !cfg.float_mode ||
            cfg.filter_time_constant == 0)
         e = x;
      else
         e = y + (((x - y) * g) >>> 16);
      if (cfg.alarms_off) begin
         ov = 1'b0;
         un = 1'b0;
      end
      d = x > prev ? x - prev : prev - x;
      rt = !first && cfg.float_mode && !cfg.alarms_off && d * 1000 >
         longint'(cfg.rate_trig) * longint'(cfg.rts_ms);
      st = {e >= lim.hh, e >= lim.hi, e <= lim.lo, e <= lim.ll};
      hd = {e >= lim.hh - lim.deadband, e >= lim.hi - lim.deadband,
         e <= lim.lo + lim.deadband, e <= lim.ll + lim.deadband};
      if (!cfg.float_mode || cfg.alarms_off)
         exp_alarm = '0;
      else if (cfg.latch_en)
         exp_alarm = st | exp_alarm;
      else
         exp_alarm = st | (exp_alarm & hd);
      c0 = got_count;
      @(negedge clk_in);
      sample <= s[`SAMPLE_W-1:0];
      sample_valid <= 1'b1;
      @(negedge clk_in);
      sample_valid <= 1'b0;
      check("busy", busy, 1'b1);
      for (n = 0; n < 40 && got_count == c0; n++)
         @(negedge clk_in);
      check("result", n < 40, 1'b1);
      check("data", got_data, e);
      check("over", got_flags[1], ov);
      check("under", got_flags[0], un);
      check("alarm", got_flags[5:2], exp_alarm);
      check("rate", got_flags[6], rt);
      check("fault", got_flags[7], wire_off);
      check("idle", busy, 1'b0);
      y = e;
      prev = x;
      first = 1'b0;
   endtask

   initial begin
      void'($urandom(32'hECB909A3));
      cfg.rts_ms = 16'h000A;
      cfg.rate_trig = 48'sh7FFF_FFFF_FFFF;
      cfg.scale_hi = 48'sh3039;
      cfg.scale_lo = -48'sh3039;
      do_reset();
      // Alarms are disabled only as on an unused channel
      for (int a = 0; a < 2; a++) begin
         cfg.alarms_off = a[0];
         for (int k = 0; k < 6; k++) begin
            cfg.kind = k > 3 ? KIND_MV : KIND_OHM;
            cfg.range = k[1:0];
            send(lo_tab[k] - 1);
            send(lo_tab[k]);
            send(hi_tab[k]);
            send(hi_tab[k] + 1);
            send(lo_tab[k] + $urandom_range(1000, 1));
         end
      end
      cfg.alarms_off = 1'b0;
      cfg.kind = KIND_OHM;
      cfg.range = 2'b00;
      cfg.copper = 1'b1;
      cfg.offset_code = -8'sh1A;
      send(hi_tab[0] + 26 * `OFFSET_STEP);
      send(hi_tab[0] + 26 * `OFFSET_STEP + 1);
      // Out-of-span code must clamp, not wrap
      cfg.offset_code = 8'sh64;
      send(lo_tab[0] - 99 * `OFFSET_STEP);
      send(lo_tab[0] - 99 * `OFFSET_STEP - 1);
      cfg.copper = 1'b0;
      send(hi_tab[0] + 1);
      do_reset();
      cfg.float_mode = 1'b1;
      cfg.range = 2'b11;
      cfg.filter_time_constant = 16'h001E;
      repeat (20) send(longint'($urandom_range(32'hFFFF_FFFF)));
      cfg.filter_time_constant = 16'h0000;
      repeat (3) send(longint'($urandom));
      foreach (alarm_seq[i]) send(alarm_seq[i]);
      cfg.latch_en = 1'b1;
      send(64'sh15E);
      send(64'sh0);
      @(negedge clk_in);
      clr <= 1'b1;
      @(negedge clk_in);
      clr <= 1'b0;
      exp_alarm = '0;
      send(64'sh0);
      cfg.latch_en = 1'b0;
      cfg.rate_trig = 48'sh3E8;
      foreach (rate_seq[i]) send(rate_seq[i]);
      cfg.float_mode = 1'b0;
      send(64'sh7FFF);
      for (int w = 0; w < 5; w++) begin
         cfg.kind = (w == 2 || w == 3) ? KIND_MV : KIND_OHM;
         cfg.float_mode = w != 3;
         cfg.alarms_off = w == 4;
         wire_a <= w == 0;
         wire_off <= 1'b1;
         repeat (4) @(negedge clk_in);
         send(longint'($urandom_range(32'hFFFF)));
      end
      cfg.alarms_off = 1'b0;
      wire_off <= 1'b0;
      repeat (4) @(negedge clk_in);
      // A sample offered while frozen must be ignored
      held = got_count;
      ce <= 1'b0;
      sample_valid <= 1'b1;
      repeat (4) @(negedge clk_in);
      sample_valid <= 1'b0;
      ce <= 1'b1;
      repeat (4) @(negedge clk_in);
      check("frozen", got_count, held);
      send(64'sh10);
      final_report();
   end
endmodule
